// ==== rtl/area_decode_bus_width_pccard.sv ====
`timescale 1ns/1ps
`include "area_decode_defines.svh"
module area_decode_bus_width_pccard
  import area_decode_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  // Mode pins
  input  wire logic        width_sel_hi_pin_i,
  input  wire logic        width_sel_lo_pin_i,
  input  wire logic        endian_pin_i,
  // Configuration
  input  wire logic [9:0]  area_width_config_i,
  input  wire logic        dram_area2_i,
  input  wire logic        dram_area3_i,
  input  wire logic        dram_memory_config_i,
  input  wire logic        card5_en_i,
  input  wire logic        card6_en_i,
  input  wire logic        card_segment_i,
  // Access request
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic        write_i,
  input  wire logic [1:0]  be_i,
  input  wire logic        io_space_i,
  input  wire logic        burst_i,
  output logic             ack_o,
  output logic             err_o,
  // Card status pin
  input  wire logic        card_io16_i,
  // Area selects
  output logic             area0_select_o,
  output logic             area2_select_o,
  output logic             area3_select_o,
  output logic             area4_select_o,
  output logic             area5_select_o,
  output logic             area6_select_o,
  // Card enables and strobes
  output logic             card_low_enable_area5_o,
  output logic             card_high_enable_area5_o,
  output logic             card_low_enable_area6_o,
  output logic             card_high_enable_area6_o,
  output logic             rd_strobe_o,
  output logic             wr_strobe_o,
  output logic             card_io_read_strobe_o,
  output logic             card_io_write_strobe_o,
  // Bus shape
  output logic [25:0]      card_addr_o,
  output logic [1:0]       bus_width_o,
  output logic [1:0]       area0_width_o,
  output logic             little_endian_o
);

  state_s      s;
  state_s      next_s;
  width_t      res_width;
  logic [2:0]  req_area;
  logic        req_card;
  logic        req_io;
  logic        req_split;
  logic [1:0]  lanes;

  assign req_area = addr_i[`AREA_SEL_MSB:`AREA_SEL_LSB];

  area_width_resolve u_width (
    .area_i               (req_area),
    .area0_width_i        (s.area0_width),
    .area_width_config_i  (area_width_config_i),
    .dram_area2_i         (dram_area2_i),
    .dram_area3_i         (dram_area3_i),
    .dram_memory_config_i (dram_memory_config_i),
    .width_o              (res_width)
  );

  always_comb begin
    next_s = s;
    next_s.mode_sync1 = {width_sel_hi_pin_i, width_sel_lo_pin_i, endian_pin_i};
    next_s.mode_sync2 = s.mode_sync1;
    next_s.io16_sync1 = card_io16_i;
    next_s.io16_sync2 = s.io16_sync1;
    next_s.ack = 1'b0;
    next_s.err = 1'b0;
    // card port in areas 5 and 6
    req_card = (req_area == `AREA_CARD5 && card5_en_i) ||
               (req_area == `AREA_CARD6 && card6_en_i);
    // no I/O cycles in area 5
    req_io = req_card && req_area == `AREA_CARD6 && io_space_i;
    req_split = req_io && s.little_endian && !s.io16_sync2 && be_i == 2'h3;
    lanes = card_lanes(be_i, res_width == `WID_BYTE, req_split);
    case (s.st)
      S_IDLE: begin
        if (req_i) begin
          if (req_area == `AREA_RESERVED) begin
            next_s.ack = 1'b1;
            next_s.err = 1'b1;
          end else if (req_area == `AREA_INTERNAL) begin
            next_s.ack = 1'b1;
          end else begin
            next_s.st = S_ACCESS;
            next_s.area = req_area;
            next_s.card = req_card;
            next_s.split = req_split;
            next_s.half = 1'b0;
            next_s.cnt = 3'h0;
            next_s.width = res_width;
            next_s.beats_left = (req_card && burst_i && !req_io) ? `BURST_BEATS : 3'h1;
            next_s.sel = 7'h0;
            next_s.sel[req_area] = 1'b1;
            next_s.ce_lo5 = req_card && req_area == `AREA_CARD5 && lanes[0];
            next_s.ce_hi5 = req_card && req_area == `AREA_CARD5 && lanes[1];
            next_s.ce_lo6 = req_card && req_area == `AREA_CARD6 && lanes[0];
            next_s.ce_hi6 = req_card && req_area == `AREA_CARD6 && lanes[1];
            next_s.iord = req_io && !write_i;
            next_s.iowr = req_io && write_i;
            next_s.rd = !req_io && !write_i;
            next_s.wr = !req_io && write_i;
            next_s.card_addr = {req_card ? card_segment_i : addr_i[25], addr_i[24:0]};
          end
        end
      end
      S_ACCESS: begin
        next_s.cnt = s.cnt + 3'h1;
        if (s.cnt == 3'(`ACCESS_CYCLES - 1)) begin
          next_s.cnt = 3'h0;
          if (s.split && !s.half) begin
            // Second byte of the halfword goes to the odd address
            next_s.half = 1'b1;
            next_s.card_addr[0] = 1'b1;
          end else if (s.beats_left > 3'h1) begin
            next_s.ack = 1'b1;
            next_s.beats_left = s.beats_left - 3'h1;
            next_s.card_addr = s.card_addr + 26'h2;
          end else begin
            next_s.ack = 1'b1;
            next_s.st = S_IDLE;
            next_s.sel = 7'h0;
            next_s.ce_lo5 = 1'b0;
            next_s.ce_hi5 = 1'b0;
            next_s.ce_lo6 = 1'b0;
            next_s.ce_hi6 = 1'b0;
            next_s.rd = 1'b0;
            next_s.wr = 1'b0;
            next_s.iord = 1'b0;
            next_s.iowr = 1'b0;
            next_s.split = 1'b0;
            next_s.card = 1'b0;
          end
        end
      end
      default: begin
        next_s.st = S_IDLE;
      end
    endcase
    if (rst_i) begin
      next_s = '0;
      next_s.mode_sync1 = {width_sel_hi_pin_i, width_sel_lo_pin_i, endian_pin_i};
      next_s.mode_sync2 = s.mode_sync1;
      next_s.io16_sync1 = card_io16_i;
      next_s.io16_sync2 = s.io16_sync1;
      next_s.st = S_IDLE;
      next_s.area0_width = pin_width(s.mode_sync2[2:1]);
      next_s.little_endian = s.mode_sync2[0];
    end
  end

  // Synchronous reset only; held reset keeps the pin latch tracking the pins
  always_ff @(posedge ref_clk_i) begin
    s <= next_s;
  end

  assign ack_o = s.ack;
  assign err_o = s.err;
  assign area0_select_o = s.sel[0];
  assign area2_select_o = s.sel[2];
  assign area3_select_o = s.sel[3];
  assign area4_select_o = s.sel[4];
  assign area5_select_o = s.sel[5];
  assign area6_select_o = s.sel[6];
  assign card_low_enable_area5_o = s.ce_lo5;
  assign card_high_enable_area5_o = s.ce_hi5;
  assign card_low_enable_area6_o = s.ce_lo6;
  assign card_high_enable_area6_o = s.ce_hi6;
  assign rd_strobe_o = s.rd;
  assign wr_strobe_o = s.wr;
  assign card_io_read_strobe_o = s.iord;
  assign card_io_write_strobe_o = s.iowr;
  assign card_addr_o = s.card_addr;
  assign bus_width_o = s.width;
  assign area0_width_o = s.area0_width;
  assign little_endian_o = s.little_endian;

  property p_area0_width;
    @(posedge ref_clk_i) disable iff (rst_i)
      !$past(rst_i) |-> $stable(s.area0_width);
  endproperty
  a_area0_width: assert property (p_area0_width)
    else $error("area 0 width changed after reset");

  property p_shadow_decode;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s.st == S_IDLE && req_i && addr_i[28:26] == 3'h6) |=> area6_select_o;
  endproperty
  a_shadow_decode: assert property (p_shadow_decode)
    else $error("area 6 not selected for its address");

  property p_area0_select;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(area0_select_o) |-> $past(addr_i[28:26]) == 3'h0;
  endproperty
  a_area0_select: assert property (p_area0_select)
    else $error("area 0 select for another area");

  property p_io_area6;
    @(posedge ref_clk_i) disable iff (rst_i)
      (card_io_read_strobe_o || card_io_write_strobe_o) |-> area6_select_o && !rd_strobe_o;
  endproperty
  a_io_area6: assert property (p_io_area6)
    else $error("card I/O strobe outside area 6");

  property p_no_io_area5;
    @(posedge ref_clk_i) disable iff (rst_i)
      area5_select_o |-> !card_io_read_strobe_o && !card_io_write_strobe_o;
  endproperty
  a_no_io_area5: assert property (p_no_io_area5)
    else $error("I/O card cycle in area 5");

  property p_enable_with_select;
    @(posedge ref_clk_i) disable iff (rst_i)
      (card_high_enable_area6_o || card_low_enable_area6_o) |-> area6_select_o;
  endproperty
  a_enable_with_select: assert property (p_enable_with_select)
    else $error("card enable without area select");

  property p_dram_width;
    @(posedge ref_clk_i) disable iff (rst_i)
      (area2_select_o && dram_area2_i && $stable(dram_area2_i)) |-> bus_width_o != `WID_BYTE;
  endproperty
  a_dram_width: assert property (p_dram_width)
    else $error("DRAM area at byte width");

  property p_big_no_split;
    @(posedge ref_clk_i) disable iff (rst_i)
      (!little_endian_o && $rose(card_io_read_strobe_o || card_io_write_strobe_o))
        |-> ##2 ack_o;
  endproperty
  a_big_no_split: assert property (p_big_no_split)
    else $error("dynamic sizing in big endian");

  property p_split_two;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s.split && s.st == S_ACCESS && !s.half) |-> !ack_o;
  endproperty
  a_split_two: assert property (p_split_two)
    else $error("split access acknowledged after one byte");

  property p_segment;
    @(posedge ref_clk_i) disable iff (rst_i)
      ($rose(area5_select_o) && s.card) |-> card_addr_o[25] == $past(card_segment_i);
  endproperty
  a_segment: assert property (p_segment)
    else $error("segment bit not driven");

  property p_ack_bound;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s.st == S_IDLE && req_i && addr_i[28:26] != 3'h1 && addr_i[28:26] != 3'h7)
        |-> ##[1:20] ack_o;
  endproperty
  a_ack_bound: assert property (p_ack_bound)
    else $error("access not acknowledged");

  property p_idle_quiet;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s.st == S_IDLE) |-> {area6_select_o, area5_select_o, area4_select_o,
                            area3_select_o, area2_select_o, area0_select_o} == 6'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("area select outside an access");

  property p_one_select;
    @(posedge ref_clk_i) disable iff (rst_i)
      $onehot0({area6_select_o, area5_select_o, area4_select_o,
                area3_select_o, area2_select_o, area0_select_o});
  endproperty
  a_one_select: assert property (p_one_select)
    else $error("more than one area selected");

  property p_area5_enable;
    @(posedge ref_clk_i) disable iff (rst_i)
      (card_high_enable_area5_o || card_low_enable_area5_o) |-> area5_select_o;
  endproperty
  a_area5_enable: assert property (p_area5_enable)
    else $error("area 5 card enable without area select");

  // A split transfer moves one byte at a time on the low lane
  property p_split_lane;
    @(posedge ref_clk_i) disable iff (rst_i)
      (s.split && s.st == S_ACCESS) |-> !card_high_enable_area6_o;
  endproperty
  a_split_lane: assert property (p_split_lane)
    else $error("upper card enable during split access");

  property p_burst_step;
    @(posedge ref_clk_i) disable iff (rst_i)
      (ack_o && s.st == S_ACCESS) |-> card_addr_o == $past(card_addr_o) + 26'h2;
  endproperty
  a_burst_step: assert property (p_burst_step)
    else $error("burst beat address not advanced");

endmodule

// ==== rtl/area_decode_defines.svh ====
// Functional notes
// - Latch two width pins at reset: 01 byte, 10 word, 11 longword, 00 reserved.
// - Areas 2 to 6 with ordinary memory or ROM take width from config.
// - DRAM areas run word or longword only, chosen by DRAM config.
// - Areas decode from address bits 28 to 26; bits 31 to 29 ignored.
// - Area 5 offers memory-card cycles only, never I/O-card cycles.
// - Area 6 serves memory cards and I/O cards over one interface.
// - Card cycles follow memory and I/O card protocols, plus burst access.
// - I/O card transfers split by card width only in little-endian mode.
// - A segment address bit reaches 64 Mbytes of card common memory.
// - Each card area drives its own upper-byte card enable.
// - Each area select is asserted only while that area is accessed.
// - Card accesses assert the area select with matching byte enables.
`ifndef AREA_DECODE_DEFINES_SVH
`define AREA_DECODE_DEFINES_SVH

`define WID_RSVD       2'h0
`define WID_BYTE       2'h1
`define WID_WORD       2'h2
`define WID_LONG       2'h3

`define AREA_SEL_MSB   28
`define AREA_SEL_LSB   26
`define AREA_INTERNAL  3'h1
`define AREA_CARD5     3'h5
`define AREA_CARD6     3'h6
`define AREA_RESERVED  3'h7

`define CLK_PERIOD_NS  40
`define ACCESS_TIME_NS 80
`define ACCESS_CYCLES  ((`ACCESS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BURST_BEATS    3'h4

`endif

// ==== rtl/area_decode_pkg.sv ====
package area_decode_pkg;

  typedef logic [1:0] width_t;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ACCESS
  } state_e;

  typedef struct packed {
    logic [2:0]  mode_sync1;
    logic [2:0]  mode_sync2;
    logic        io16_sync1;
    logic        io16_sync2;
    width_t      area0_width;
    logic        little_endian;
    state_e      st;
    logic [2:0]  area;
    logic        card;
    logic        split;
    logic        half;
    logic [2:0]  beats_left;
    logic [2:0]  cnt;
    logic [6:0]  sel;
    logic        ce_lo5;
    logic        ce_hi5;
    logic        ce_lo6;
    logic        ce_hi6;
    logic        rd;
    logic        wr;
    logic        iord;
    logic        iowr;
    logic [25:0] card_addr;
    width_t      width;
    logic        ack;
    logic        err;
  } state_s;

  // Width pins code to bus width; 00 stays reserved
  function automatic width_t pin_width(input logic [1:0] code);
    pin_width = code;
  endfunction

  // Returns {high, low} card enables
  function automatic logic [1:0] card_lanes(input logic [1:0] be, input logic byte_bus,
                                            input logic split);
    if (split || byte_bus) begin
      card_lanes = 2'h1;
    end else begin
      card_lanes = be;
    end
  endfunction

endpackage

// ==== rtl/area_width_resolve.sv ====
`timescale 1ns/1ps
`include "area_decode_defines.svh"
module area_width_resolve
  import area_decode_pkg::*;
(
  // Access
  input  wire logic [2:0] area_i,
  // Configuration
  input  wire width_t     area0_width_i,
  input  wire logic [9:0] area_width_config_i,
  input  wire logic       dram_area2_i,
  input  wire logic       dram_area3_i,
  input  wire logic       dram_memory_config_i,
  // Result
  output logic [1:0]      width_o
);

  always_comb begin
    width_o = `WID_RSVD;
    if (area_i == 3'h0) begin
      width_o = area0_width_i;
    end else if ((area_i == 3'h2 && dram_area2_i) || (area_i == 3'h3 && dram_area3_i)) begin
      width_o = dram_memory_config_i ? `WID_LONG : `WID_WORD;
    end else if (area_i >= 3'h2 && area_i <= 3'h6) begin
      width_o = area_width_config_i[{area_i - 3'h2, 1'b0} +: 2];
    end
  end

endmodule

// ==== bench/card_model.sv ====
`timescale 1ns/1ps
module card_model (
  // Card kind
  input  wire logic io_card_i,
  input  wire logic port16_i,
  // Shared pin
  output logic      card_io16_o
);
  // port size pin
  // A memory card reports no write protect here, so the pin reads low
  assign card_io16_o = io_card_i & port16_i;
endmodule

// ==== bench/area_decode_bus_width_pccard_test.sv ====
`timescale 1ns/1ps
module area_decode_bus_width_pccard_test;
  import area_decode_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wsel_hi = 1'b0;
  logic        wsel_lo = 1'b1;
  logic        endian = 1'b1;
  // card areas 5 and 6 at word
  logic [9:0]  wcfg = 10'h2ad;
  logic        dram2 = 1'b0;
  logic        dram3 = 1'b0;
  logic        dram_cfg = 1'b0;
  logic        seg = 1'b0;
  logic        card6 = 1'b1;
  logic        req = 1'b0;
  logic [31:0] addr = 32'h0;
  logic        wr = 1'b0;
  logic [1:0]  be = 2'h3;
  logic        io = 1'b0;
  logic        burst = 1'b0;
  logic        io_card = 1'b0;
  logic        port16 = 1'b0;
  wire         io16;
  logic        ack, err, s0, s2, s3, s4, s5, s6, lo5, hi5, lo6, hi6, rd, wrs, iord, iowr;
  logic [25:0] caddr, first_ca, last_ca;
  logic [1:0]  bw, a0w, bw_seen;
  logic        le, err_seen;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n;

  always #20 ref_clk_i = ~ref_clk_i;

  card_model model_u (.io_card_i(io_card), .port16_i(port16), .card_io16_o(io16));

  area_decode_bus_width_pccard dut_u (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .width_sel_hi_pin_i(wsel_hi), .width_sel_lo_pin_i(wsel_lo), .endian_pin_i(endian),
    .area_width_config_i(wcfg), .dram_area2_i(dram2), .dram_area3_i(dram3),
    .dram_memory_config_i(dram_cfg), .card5_en_i(1'b1), .card6_en_i(card6),
    .card_segment_i(seg), .req_i(req), .addr_i(addr), .write_i(wr), .be_i(be),
    .io_space_i(io), .burst_i(burst), .ack_o(ack), .err_o(err), .card_io16_i(io16),
    .area0_select_o(s0), .area2_select_o(s2), .area3_select_o(s3),
    .area4_select_o(s4), .area5_select_o(s5), .area6_select_o(s6),
    .card_low_enable_area5_o(lo5), .card_high_enable_area5_o(hi5),
    .card_low_enable_area6_o(lo6), .card_high_enable_area6_o(hi6),
    .rd_strobe_o(rd), .wr_strobe_o(wrs), .card_io_read_strobe_o(iord),
    .card_io_write_strobe_o(iowr), .card_addr_o(caddr), .bus_width_o(bw),
    .area0_width_o(a0w), .little_endian_o(le)
  );

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Pins are {selects 6,5,4,3,2,0, enables hi6,lo6,hi5,lo5, iowr,iord,wr,rd}
  task automatic run(input logic [31:0] a, input logic w, input logic [1:0] b, input logic i,
                     input logic bu, input logic [13:0] ep, input int ea, input int el);
    int k;
    int na;
    int lat;
    @(posedge ref_clk_i);
    req <= 1'b1;
    addr <= a;
    wr <= w;
    be <= b;
    io <= i;
    burst <= bu;
    @(posedge ref_clk_i);
    req <= 1'b0;
    na = 0;
    lat = -1;
    err_seen = 1'b0;
    @(negedge ref_clk_i);
    chk("pins", ep, {s6, s5, s4, s3, s2, s0, hi6, lo6, hi5, lo5, iowr, iord, wrs, rd});
    first_ca = caddr;
    last_ca = caddr;
    bw_seen = bw;
    for (k = 0; k < 16 && na < ea; k++) begin
      if (k > 0) @(negedge ref_clk_i);
      if (ack === 1'b1) begin
        na++;
        if (lat < 0) lat = k;
        err_seen = err_seen | err;
      end else begin
        last_ca = caddr;
      end
    end
    chk("acks", ea, na);
    chk("latency", el, lat);
    // Selects must already be gone in the cycle of the last ack
    chk("sel_after", 6'h0, {s6, s5, s4, s3, s2, s0});
  endtask

  task automatic end_of_test;
    $display("Errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #(40 * 3000);
    n_errors++;
    end_of_test;
  end

  initial begin
    for (n = 1; n < 4; n++) begin
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      {wsel_hi, wsel_lo} <= n[1:0];
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      // Pins move after release; the latch must hold its value
      {wsel_hi, wsel_lo} <= ~n[1:0];
      repeat (4) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk("area0_width", n[1:0], a0w);
      chk("little_endian", 1'b1, le);
    end
    run(32'h2000_0010, 1'b0, 2'h3, 1'b0, 1'b0, 14'h0101, 1, 2);
    chk("width0", 2'h3, bw_seen);
    for (n = 2; n < 5; n++) begin
      run({3'h1, n[2:0], 26'h40}, 1'b0, 2'h3, 1'b0, 1'b0,
          14'h0001 | (14'h0080 << n), 1, 2);
      chk("width", wcfg[2 * (n - 2) +: 2], bw_seen);
    end
    run(32'h0400_0000, 1'b0, 2'h3, 1'b0, 1'b0, 14'h0000, 1, 0);
    run(32'h1c00_0000, 1'b0, 2'h3, 1'b0, 1'b0, 14'h0000, 1, 0);
    chk("err", 1'b1, err_seen);
    @(posedge ref_clk_i);
    dram2 <= 1'b1;
    run(32'h0800_0000, 1'b0, 2'h3, 1'b0, 1'b0, 14'h0201, 1, 2);
    chk("dram_width2", 2'h2, bw_seen);
    @(posedge ref_clk_i);
    dram2 <= 1'b0;
    dram3 <= 1'b1;
    dram_cfg <= 1'b1;
    run(32'h0c00_0000, 1'b0, 2'h3, 1'b0, 1'b0, 14'h0401, 1, 2);
    chk("dram_width3", 2'h3, bw_seen);
    @(posedge ref_clk_i);
    dram3 <= 1'b0;
    run(32'h1400_0000, 1'b0, 2'h3, 1'b1, 1'b0, 14'h1031, 1, 2);
    @(posedge ref_clk_i);
    seg <= 1'b1;
    run(32'h1400_0100, 1'b0, 2'h3, 1'b0, 1'b1, 14'h1031, 4, 2);
    chk("card_seg", 26'h200_0100, first_ca);
    chk("burst_step", 26'h200_0106, last_ca);
    @(posedge ref_clk_i);
    seg <= 1'b0;
    io_card <= 1'b1;
    port16 <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    run(32'h1800_0020, 1'b0, 2'h3, 1'b1, 1'b0, 14'h20c4, 1, 2);
    @(posedge ref_clk_i);
    port16 <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    run(32'h1800_0020, 1'b1, 2'h3, 1'b1, 1'b0, 14'h2048, 1, 4);
    chk("split_lsb", 2'h2, {last_ca[0], first_ca[0]});
    @(posedge ref_clk_i);
    io_card <= 1'b0;
    run(32'h1800_0040, 1'b1, 2'h2, 1'b0, 1'b0, 14'h2082, 1, 2);
    // Big-endian restart: an 8-bit port read at the same address must not split
    @(posedge ref_clk_i);
    rst_i <= 1'b1;
    {wsel_hi, wsel_lo} <= 2'h3;
    endian <= 1'b0;
    io_card <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(negedge ref_clk_i);
    chk("area0_width", 2'h3, a0w);
    chk("little_endian", 1'b0, le);
    run(32'h1800_0020, 1'b0, 2'h3, 1'b1, 1'b0, 14'h20c4, 1, 2);
    // Area 6 without the card interface runs ordinary memory strobes
    @(posedge ref_clk_i);
    card6 <= 1'b0;
    run(32'h1800_0040, 1'b0, 2'h3, 1'b1, 1'b0, 14'h2001, 1, 2);
    end_of_test;
  end
endmodule
